/* File: vcm_regs.svh */
// Purpose: Constants for the vacuum condition monitor.
// Assumes: 100 MHz clock, vacuum and pressure in mbar.
// Notes:   Flag byte bits and timing figures live here.
// Functional notes
// - Over six switchovers in 3 s forces continuous suction.
// - Switching fault: diag, flash green, bit 0, event.
// - Inhibit setting blocks forced continuous suction.
// - Upper point missed: diag, flash red, bit 3.
// - Evacuation time over limit: diag, red, bit 1.
// - Evacuation limit up to 9.99 s, zero disables.
// - Small decay: suction resumes below hysteresis point.
// - Second leak exceedance: continuous suction, diag, bit 2.
// - Leak check every control cycle, seven limit values.
// - Supply pressure out of limits sets bit 7.
// - Dynamic pressure in window sets bit 4.
// - Pressure faults leave indicator and diag alone.
// - Diag output holds until next cycle start.
// - Live level during cycle, fault colour after.
// - Leakage averaged over last 16 cycles.
// - Upper point missed: record worst leakage class.
// - Hysteresis below 22 mbar disables analysis, leak-tight.
// - Analysis request pulse over 50 ms, not during suction or blow-off.
// - Analysis drives outputs and colour by average class.
// - New suction or blow-off ends analysis.
// - Leak class published at next cycle start.
// - Times t0 and t1 in ms published at start.
// - A clock that newly sets any flag bit increments event counter once.
`ifndef VCM_REGS_SVH
`define VCM_REGS_SVH
`define VCM_FLAGS_OFS    16'h0092
`define VCM_B_SWF        0
`define VCM_B_EVAC       1
`define VCM_B_LEAK       2
`define VCM_B_THR        3
`define VCM_B_DYN        4
`define VCM_B_EVT        6
`define VCM_B_PRS        7
`define VCM_CLK_NS       10
`define VCM_MS_NS        1000000
`define VCM_SW_MAX       6
`define VCM_SW_WIN_MS    16'h0BB8
`define VCM_EVAC_MAX     10'h3E7
`define VCM_EVAC_UNIT    4'hA
`define VCM_REQ_MS       16'h0032
`define VCM_DYN_MS       16'h03E8
`define VCM_HYS_MIN      10'h016
`define VCM_LEAK_BAD     10'h3FF
`define VCM_CLS_A        10'h043
`define VCM_CLS_B        10'h085
`define VCM_CLS_C        10'h0C8
`define VCM_AVG_N        16
`define VCM_LIM0         10'h004
`define VCM_LIM1         10'h00B
`define VCM_LIM2         10'h019
`define VCM_LIM3         10'h032
`define VCM_LIM4         10'h064
`define VCM_LIM5         10'h096
`define VCM_LIM6         10'h0FA
`endif

/* File: vcm_pkg.sv */
// Purpose: Types for the vacuum condition monitor.
// Assumes: Nothing beyond the constants header.
// Notes:   Phase codes are Gray along idle, suction, held.
package vcm_pkg;
	typedef enum logic [1:0] {
		VCM_IDLE = 2'b00,
		VCM_SUCK = 2'b01,
		VCM_HELD = 2'b11
	} vcm_phase_t;
	typedef enum logic [1:0] {
		VCM_LED_OFF   = 2'b00,
		VCM_LED_GREEN = 2'b01,
		VCM_LED_RED   = 2'b10
	} vcm_led_t;
endpackage

/* File: vcm_avg16.sv */
// Purpose: Running average of the most recent N leakage samples.
// Assumes: N is a power of two.
// Notes:   Entries start at zero, so early averages read low.
`timescale 1ns/100ps
module vcm_avg16 #(
	parameter int W = 10,
	parameter int N = 16
)(
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	input  wire logic         ce_in,
	input  wire logic         push_in,
	input  wire logic [W-1:0] data_in,
	output logic      [W-1:0] avg_out
);
	localparam int LW = $clog2(N);
	if (N < 2 || (1 << LW) != N) begin : g_bad
		$error("Depth must be a power of two.");
	end
	logic [W-1:0]    mem [N];
	logic [LW-1:0]   idx;
	logic [W+LW-1:0] sum;
	logic [W+LW-1:0] next_sum;
	assign next_sum = sum + {{LW{1'b0}}, data_in} - {{LW{1'b0}}, mem[idx]};
	// ************************************************************
	// Sample storage, one flip-flop word per entry.
	// ************************************************************
	for (genvar i = 0; i < N; i++) begin : g_ent
		always_ff @(posedge clk_in or negedge resetn_in) begin
			if (!resetn_in) begin
				mem[i] <= '0;
			end else if (ce_in && push_in && idx == LW'(i)) begin
				mem[i] <= data_in;
			end
		end
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			idx     <= '0;
			sum     <= '0;
			avg_out <= '0;
		end else if (ce_in && push_in) begin
			idx     <= idx + LW'(1);
			sum     <= next_sum;
			avg_out <= next_sum[W+LW-1:LW];
		end
	end
endmodule

/* File: vcm_monitor.sv */
// Purpose: Condition monitoring for a vacuum ejector controller.
// Assumes: Inputs synchronous to clk_in; leak_valid_in pulses once per control cycle.
// Notes:   Flag byte at its fieldbus offset is driven on fault_flags_out.
`include "vcm_regs.svh"
`timescale 1ns/100ps
module vcm_monitor
	import vcm_pkg::*;
#(
	parameter int MS_CYC = `VCM_MS_NS / `VCM_CLK_NS
)(
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       ce_in,
	input  wire logic       suction_cmd_in,
	input  wire logic       blowoff_cmd_in,
	input  wire logic       air_saving_en_in,
	input  wire logic       self_monitored_control_in,
	input  wire logic       continuous_suction_inhibit_in,
	input  wire logic [9:0] vacuum_in,
	input  wire logic [9:0] upper_switch_point_in,
	input  wire logic [9:0] upper_hysteresis_in,
	input  wire logic [9:0] part_present_point_in,
	input  wire logic [9:0] part_present_hysteresis_in,
	input  wire logic [9:0] evac_limit_in,
	input  wire logic [2:0] leak_limit_sel_in,
	input  wire logic       leak_valid_in,
	input  wire logic [9:0] leak_rate_in,
	input  wire logic       pressure_sensor_present_in,
	input  wire logic [9:0] supply_pressure_in,
	input  wire logic [9:0] pressure_min_in,
	input  wire logic [9:0] pressure_max_in,
	input  wire logic       analysis_request_input_in,
	input  wire logic       first_output_nc_in,
	input  wire logic       diag_output_nc_in,
	output logic            nozzle_on_out,
	output logic            continuous_suction_out,
	output logic            first_signal_output_out,
	output logic            diag_output_out,
	output vcm_led_t        led_colour_out,
	output logic            led_flash_out,
	output logic            analysis_display_code_out,
	output logic [7:0]      fault_flags_out,
	output logic            process_event_bit_out,
	output logic [15:0]     cm_event_count_out,
	output logic [1:0]      leak_class_out,
	output logic [15:0]     t0_ms_out,
	output logic [15:0]     t1_ms_out
);
	localparam int DW = $clog2(MS_CYC + 1);
	localparam int SW = `VCM_SW_MAX;
	if (MS_CYC < 1) begin : g_bad
		$error("MS_CYC must be at least one.");
	end
	vcm_phase_t  phase;
	logic [DW-1:0] ms_div;
	logic        ms_tick;
	logic [15:0] now_ms;
	logic        suct_q;
	logic        blow_q;
	logic        req_q;
	logic        cyc_start;
	logic        cyc_end;
	logic        blow_rise;
	logic        reached_hi;
	logic        reached_pp;
	logic        at_hi;
	logic [15:0] t0_cnt;
	logic [15:0] t1_cnt;
	logic [15:0] cyc_ms;
	logic        nozzle_q;
	logic        sw_ev;
	logic [15:0] ts [SW];
	logic [SW-1:0] tv;
	logic        force_cont;
	logic [1:0]  leak_cnt;
	logic [7:0]  flags;
	logic [7:0]  set_vec;
	logic        diag;
	logic        new_ev;
	logic [9:0]  leak_meas;
	logic        leak_seen;
	logic        avg_push;
	logic [9:0]  avg_val;
	logic [9:0]  push_val;
	logic [1:0]  cls;
	logic        ana_off;
	logic        ana_active;
	logic [15:0] req_ms;
	logic [9:0]  leak_lim;
	logic [9:0]  hi_lo;
	logic [9:0]  pp_lo;
	logic [13:0] evac_ms;
	logic        leak_over;
	logic        sw_fault;
	logic        leak_fault;
	assign ms_tick   = ms_div == DW'(MS_CYC - 1);
	assign cyc_start = suction_cmd_in & ~suct_q;
	assign cyc_end   = ~suction_cmd_in & suct_q;
	assign blow_rise = blowoff_cmd_in & ~blow_q;
	assign at_hi     = vacuum_in >= upper_switch_point_in;
	assign hi_lo = (upper_hysteresis_in > upper_switch_point_in) ? 10'h000 :
		upper_switch_point_in - upper_hysteresis_in;
	assign pp_lo = (part_present_hysteresis_in > part_present_point_in) ? 10'h000 :
		part_present_point_in - part_present_hysteresis_in;
	assign evac_ms = ((evac_limit_in > `VCM_EVAC_MAX) ? `VCM_EVAC_MAX : evac_limit_in)
		* `VCM_EVAC_UNIT;
	assign ana_off = upper_hysteresis_in < `VCM_HYS_MIN;
	// ************************************************************
	// Leak limit selection and leak class.
	// ************************************************************
	always_comb begin
		case (leak_limit_sel_in)
			3'h0:    leak_lim = `VCM_LIM0;
			3'h1:    leak_lim = `VCM_LIM1;
			3'h2:    leak_lim = `VCM_LIM2;
			3'h3:    leak_lim = `VCM_LIM3;
			3'h4:    leak_lim = `VCM_LIM4;
			3'h5:    leak_lim = `VCM_LIM5;
			default: leak_lim = `VCM_LIM6;
		endcase
	end
	always_comb begin
		if (ana_off) begin
			cls = 2'h0;
		end else if (avg_val < `VCM_CLS_A) begin
			cls = 2'h0;
		end else if (avg_val <= `VCM_CLS_B) begin
			cls = 2'h1;
		end else if (avg_val <= `VCM_CLS_C) begin
			cls = 2'h2;
		end else begin
			cls = 2'h3;
		end
	end
	assign leak_over  = phase == VCM_SUCK && self_monitored_control_in && leak_valid_in &&
		leak_rate_in > leak_lim;
	assign leak_fault = leak_over && leak_cnt == 2'h1;
	assign sw_ev      = phase == VCM_SUCK && air_saving_en_in && (nozzle_on_out ^ nozzle_q);
	assign sw_fault   = sw_ev && tv[SW-1] && (now_ms - ts[SW-1]) < `VCM_SW_WIN_MS;
	// ************************************************************
	// Fault detection.
	// ************************************************************
	always_comb begin
		set_vec              = 8'h00;
		set_vec[`VCM_B_SWF]  = sw_fault;
		set_vec[`VCM_B_EVAC] = phase == VCM_SUCK && evac_ms != 14'h0000 && reached_pp &&
			!reached_hi && t1_cnt > {2'b00, evac_ms};
		set_vec[`VCM_B_LEAK] = leak_fault;
		set_vec[`VCM_B_THR]  = cyc_end && !reached_hi && !at_hi;
		set_vec[`VCM_B_DYN]  = pressure_sensor_present_in && phase == VCM_SUCK && ms_tick &&
			cyc_ms == `VCM_DYN_MS - 16'h0001 && vacuum_in > pp_lo &&
			!at_hi;
		set_vec[`VCM_B_PRS]  = pressure_sensor_present_in && (supply_pressure_in <
			pressure_min_in || supply_pressure_in > pressure_max_in);
	end
	assign new_ev = |(set_vec & ~flags);
	// ************************************************************
	// Time base and edge capture.
	// ************************************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ms_div <= '0;
			now_ms <= 16'h0000;
		end else if (ce_in) begin
			if (ms_tick) begin
				ms_div <= '0;
				now_ms <= now_ms + 16'h0001;
			end else begin
				ms_div <= ms_div + DW'(1);
			end
		end
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			suct_q   <= 1'b0;
			blow_q   <= 1'b0;
			req_q    <= 1'b0;
			nozzle_q <= 1'b0;
		end else if (ce_in) begin
			suct_q   <= suction_cmd_in;
			blow_q   <= blowoff_cmd_in;
			req_q    <= analysis_request_input_in;
			nozzle_q <= nozzle_on_out;
		end
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			phase <= VCM_IDLE;
		end else if (ce_in) begin
			case (phase)
				VCM_IDLE: if (cyc_start) phase <= VCM_SUCK;
				VCM_SUCK: if (cyc_end) phase <= VCM_HELD;
				VCM_HELD: if (cyc_start) phase <= VCM_SUCK;
				default:  phase <= VCM_IDLE;
			endcase
		end
	end
	// ************************************************************
	// Cycle timing and published measurements.
	// ************************************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reached_hi <= 1'b0;
			reached_pp <= 1'b0;
			t0_cnt     <= 16'h0000;
			t1_cnt     <= 16'h0000;
			cyc_ms     <= 16'h0000;
			t0_ms_out  <= 16'h0000;
			t1_ms_out  <= 16'h0000;
		end else if (ce_in) begin
			if (cyc_start) begin
				t0_ms_out  <= t0_cnt;
				t1_ms_out  <= t1_cnt;
				reached_hi <= 1'b0;
				reached_pp <= 1'b0;
				t0_cnt     <= 16'h0000;
				t1_cnt     <= 16'h0000;
				cyc_ms     <= 16'h0000;
			end else if (phase == VCM_SUCK) begin
				if (at_hi) reached_hi <= 1'b1;
				if (vacuum_in >= part_present_point_in) reached_pp <= 1'b1;
				if (ms_tick) begin
					if (cyc_ms != 16'hFFFF) cyc_ms <= cyc_ms + 16'h0001;
					if (!reached_pp && t0_cnt != 16'hFFFF) begin
						t0_cnt <= t0_cnt + 16'h0001;
					end else if (reached_pp && !reached_hi && t1_cnt != 16'hFFFF) begin
						t1_cnt <= t1_cnt + 16'h0001;
					end
				end
			end
		end
	end
	// ************************************************************
	// Nozzle control and continuous suction.
	// ************************************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			nozzle_on_out <= 1'b0;
		end else if (ce_in) begin
			if (cyc_start) begin
				nozzle_on_out <= 1'b1;
			end else if (phase != VCM_SUCK || cyc_end) begin
				nozzle_on_out <= 1'b0;
			end else if (force_cont || !air_saving_en_in) begin
				nozzle_on_out <= 1'b1;
			end else if (nozzle_on_out && at_hi) begin
				nozzle_on_out <= 1'b0;
			end else if (!nozzle_on_out && (vacuum_in < hi_lo || leak_over)) begin
				nozzle_on_out <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			force_cont <= 1'b0;
			leak_cnt   <= 2'h0;
		end else if (ce_in) begin
			if (cyc_start) begin
				force_cont <= 1'b0;
				leak_cnt   <= 2'h0;
			end else begin
				if ((sw_fault || leak_fault) && !continuous_suction_inhibit_in) begin
					force_cont <= 1'b1;
				end
				if (leak_over && leak_cnt != 2'h2) leak_cnt <= leak_cnt + 2'h1;
			end
		end
	end
	assign continuous_suction_out = force_cont;
	for (genvar i = 0; i < SW; i++) begin : g_ts
		always_ff @(posedge clk_in or negedge resetn_in) begin
			if (!resetn_in) begin
				ts[i] <= 16'h0000;
				tv[i] <= 1'b0;
			end else if (ce_in) begin
				if (cyc_start) begin
					tv[i] <= 1'b0;
				end else if (sw_ev) begin
					ts[i] <= (i == 0) ? now_ms : ts[(i == 0) ? 0 : i-1];
					tv[i] <= (i == 0) ? 1'b1 : tv[(i == 0) ? 0 : i-1];
				end
			end
		end
	end
	// ************************************************************
	// Flags, diagnostics and event counter.
	// ************************************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flags              <= 8'h00;
			diag               <= 1'b0;
			cm_event_count_out <= 16'h0000;
		end else if (ce_in) begin
			flags <= (cyc_start ? 8'h00 : flags) | set_vec;
			diag  <= (cyc_start ? 1'b0 : diag) | (|set_vec[`VCM_B_THR:`VCM_B_SWF]);
			if (new_ev) cm_event_count_out <= cm_event_count_out + 16'h0001;
		end
	end
	assign fault_flags_out       = flags;
	assign process_event_bit_out = |flags;
	// ************************************************************
	// Leakage measurement and averaging.
	// ************************************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			leak_meas      <= 10'h000;
			leak_seen      <= 1'b0;
			leak_class_out <= 2'h0;
		end else if (ce_in) begin
			if (cyc_start) begin
				leak_seen      <= 1'b0;
				leak_class_out <= cls;
			end else if (phase == VCM_SUCK && leak_valid_in && reached_hi) begin
				leak_meas <= leak_rate_in;
				leak_seen <= 1'b1;
			end
		end
	end
	assign avg_push = cyc_end && !ana_off && (!(reached_hi || at_hi) || leak_seen);
	assign push_val = (reached_hi || at_hi) ? leak_meas : `VCM_LEAK_BAD;
	vcm_avg16 #(
		.W (10),
		.N (`VCM_AVG_N)
	) u_avg (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.ce_in     (ce_in),
		.push_in   (avg_push),
		.data_in   (push_val),
		.avg_out   (avg_val)
	);
	// ************************************************************
	// Analysis request and evaluation.
	// ************************************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			req_ms     <= 16'h0000;
			ana_active <= 1'b0;
		end else if (ce_in) begin
			if (!analysis_request_input_in) begin
				req_ms <= 16'h0000;
			end else if (ms_tick && req_ms != 16'hFFFF) begin
				req_ms <= req_ms + 16'h0001;
			end
			if (cyc_start || blow_rise) begin
				ana_active <= 1'b0;
			end else if (req_q && !analysis_request_input_in && req_ms > `VCM_REQ_MS &&
				phase != VCM_SUCK && !blowoff_cmd_in && !ana_off) begin
				ana_active <= 1'b1;
			end
		end
	end
	// ************************************************************
	// Output pins and status indicator.
	// ************************************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			first_signal_output_out   <= 1'b0;
			diag_output_out           <= 1'b0;
			led_colour_out            <= VCM_LED_OFF;
			led_flash_out             <= 1'b0;
			analysis_display_code_out <= 1'b0;
		end else if (ce_in) begin
			analysis_display_code_out <= ana_active;
			if (ana_active) begin
				first_signal_output_out <= ~cls[1];
				diag_output_out         <= ~cls[0];
				led_colour_out          <= cls[1] ? VCM_LED_RED : VCM_LED_GREEN;
				led_flash_out           <= cls[1] ^ cls[0];
			end else begin
				first_signal_output_out <= at_hi ^ first_output_nc_in;
				diag_output_out         <= diag ^ diag_output_nc_in;
				if (phase == VCM_SUCK) begin
					led_colour_out <= at_hi ? VCM_LED_GREEN : VCM_LED_OFF;
					led_flash_out  <= 1'b0;
				end else if (phase == VCM_HELD && (flags[`VCM_B_SWF] ||
					flags[`VCM_B_LEAK])) begin
					led_colour_out <= VCM_LED_GREEN;
					led_flash_out  <= 1'b1;
				end else if (phase == VCM_HELD && (flags[`VCM_B_EVAC] ||
					flags[`VCM_B_THR])) begin
					led_colour_out <= VCM_LED_RED;
					led_flash_out  <= 1'b1;
				end else begin
					led_colour_out <= VCM_LED_OFF;
					led_flash_out  <= 1'b0;
				end
			end
		end
	end
	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	AST_SW_FORCE: assert property (ce_in && sw_fault && !continuous_suction_inhibit_in |=>
		continuous_suction_out) else $error("Switch fault did not force suction.");
	AST_SW_FLAG: assert property (ce_in && sw_fault |=> flags[`VCM_B_SWF] && diag &&
		process_event_bit_out) else $error("Switch fault not flagged.");
	AST_INHIBIT: assert property (ce_in && continuous_suction_inhibit_in && !force_cont |=>
		!force_cont) else $error("Continuous suction forced under inhibit.");
	AST_THR: assert property (ce_in && set_vec[`VCM_B_THR] |=> flags[`VCM_B_THR] && diag
		##1 !ce_in || (led_colour_out == VCM_LED_RED || ana_active || cyc_start ||
		$past(flags[`VCM_B_SWF] || flags[`VCM_B_LEAK])))
		else $error("Threshold fault not shown.");
	AST_EVAC: assert property (ce_in && set_vec[`VCM_B_EVAC] |=> flags[`VCM_B_EVAC] && diag)
		else $error("Evacuation fault not flagged.");
	AST_EVAC_OFF: assert property (evac_limit_in == 10'h000 |-> !set_vec[`VCM_B_EVAC])
		else $error("Evacuation check active with zero limit.");
	AST_LEAK2: assert property (ce_in && leak_fault && !continuous_suction_inhibit_in |=>
		force_cont && flags[`VCM_B_LEAK] && diag) else $error("Second leak not handled.");
	AST_DIAG_HOLD: assert property (ce_in && diag && !cyc_start |=> diag [*1] ##0 $stable(diag))
		else $error("Diag output dropped inside cycle.");
	AST_PRS_QUIET: assert property (ce_in && !diag && !cyc_start &&
		set_vec[`VCM_B_THR:`VCM_B_SWF] == 4'h0 |=> !diag)
		else $error("Pressure fault touched diag.");
	AST_LIVE_LED: assert property (ce_in && phase == VCM_SUCK && !ana_active |=> !led_flash_out)
		else $error("Fault colour shown during cycle.");
	AST_ANA_END: assert property (ce_in && (cyc_start || blow_rise) |=> !ana_active ##1
		(!ce_in || !analysis_display_code_out)) else $error("Analysis not ended.");
	AST_CNT: assert property (ce_in && new_ev |=> cm_event_count_out ==
		$past(cm_event_count_out) + 16'h0001) else $error("Event not counted.");
	COV_SW: cover property (ce_in && sw_fault);
	COV_LEAK2: cover property (ce_in && leak_fault);
	COV_ANA: cover property (ce_in && ana_active && cls == 2'h3);
	COV_THR: cover property (ce_in && set_vec[`VCM_B_THR]);
endmodule

/* File: vcm_plc_model.sv */
// Purpose: Fieldbus master model: analysis pulse source and flag poller.
// Assumes: MS_CYC clock cycles per ms.
// Notes:   The flag byte is copied on every clock.
`timescale 1ns/100ps
module vcm_plc_model #(
	parameter int MS_CYC = 10
)(
	input  wire logic        clk_in,
	input  wire logic        start_in,
	input  wire logic [15:0] len_ms_in,
	input  wire logic [7:0]  flags_in,
	output logic             req_out,
	output logic [7:0]       seen_out
);
	// ********************
	// Pulse and poll
	// ********************
	int cnt = 0;
	initial req_out = 1'b0;
	always @(posedge clk_in) begin
		seen_out <= flags_in;
		if (start_in && cnt == 0) begin
			cnt <= len_ms_in * MS_CYC;
			req_out <= 1'b1;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			cnt <= 0;
			req_out <= 1'b0;
		end
	end
endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the condition monitor.
// Assumes: Ten clocks per ms in simulation.
// Notes:   Each scenario starts from reset.
`timescale 1ns/100ps
module tb;
	import vcm_pkg::*;
	// ********************
	// Signals
	// ********************
	logic        clk, rstn, sc, bo, ase, smc, inh, sens, lv, ast, req, ce, nc1, nc3;
	logic        noz, cont, o1, dg, flash, code, evt;
	logic [9:0]  vac, evl, sp, hys, lrate;
	logic [2:0]  lsel;
	logic [15:0] plen, cnt, t0, t1;
	logic [7:0]  fl, seen;
	logic [1:0]  cls;
	vcm_led_t    led;
	int          failures = 0;
	int          num_checks = 0;
	vcm_monitor #(.MS_CYC(10)) u_vcm_monitor (.clk_in(clk), .resetn_in(rstn), .ce_in(ce),
		.suction_cmd_in(sc), .blowoff_cmd_in(bo), .air_saving_en_in(ase),
		.self_monitored_control_in(smc), .continuous_suction_inhibit_in(inh),
		.vacuum_in(vac), .upper_switch_point_in(10'h1F4), .upper_hysteresis_in(hys),
		.part_present_point_in(10'h12C), .part_present_hysteresis_in(10'h014),
		.evac_limit_in(evl), .leak_limit_sel_in(lsel), .leak_valid_in(lv),
		.leak_rate_in(lrate), .pressure_sensor_present_in(sens), .supply_pressure_in(sp),
		.pressure_min_in(10'h064), .pressure_max_in(10'h2BC), .analysis_request_input_in(req),
		.first_output_nc_in(nc1), .diag_output_nc_in(nc3), .nozzle_on_out(noz),
		.continuous_suction_out(cont), .first_signal_output_out(o1), .diag_output_out(dg),
		.led_colour_out(led), .led_flash_out(flash), .analysis_display_code_out(code),
		.fault_flags_out(fl), .process_event_bit_out(evt), .cm_event_count_out(cnt),
		.leak_class_out(cls), .t0_ms_out(t0), .t1_ms_out(t1));
	vcm_plc_model #(.MS_CYC(10)) u_vcm_plc_model (.clk_in(clk), .start_in(ast),
		.len_ms_in(plen), .flags_in(fl), .req_out(req), .seen_out(seen));
	// ********************
	// Tasks
	// ********************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic rst();
		rstn = 1'b0;
		{sc, bo, ase, smc, inh, sens, lv, ast} = 8'h00;
		{vac, evl} = 20'h00000;
		sp = 10'h190;
		{ce, nc1, nc3} = 3'b100;
		hys = 10'h032;
		lrate = 10'h064;
		lsel = 3'h0;
		cyc(2);
		rstn = 1'b1;
		cyc(1);
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ********************
	// Scenarios
	// ********************
	task automatic t_thr();
		rst();
		chk(fl, 8'h00, "flags after reset");
		sc = 1;
		cyc(20);
		sc = 0;
		cyc(4);
		chk(seen, 8'h08, "threshold flag");
		chk({evt, dg, flash, led}, 5'b11110, "threshold outputs");
		chk(cnt, 16'h0001, "event count");
		sc = 1;
		vac = 10'h258;
		cyc(3);
		chk({fl, dg}, 9'h000, "cycle start clears");
		chk(led, VCM_LED_GREEN, "live level");
	endtask
	task automatic t_evac();
		rst();
		evl = 10'h001;
		sc = 1;
		vac = 10'h15E;
		cyc(150);
		vac = 10'h258;
		cyc(3);
		sc = 0;
		cyc(4);
		chk(fl, 8'h02, "evacuation flag");
		chk({dg, flash, led}, 4'b1110, "evacuation outputs");
		sc = 1;
		cyc(3);
		chk(t1, 16'h000F, "t1 published");
		chk(t0, 16'h0000, "t0 published");
	endtask
	task automatic t_swf(input logic i);
		rst();
		ase = 1;
		inh = i;
		sc = 1;
		cyc(3);
		repeat (4) begin
			vac = 10'h258;
			cyc(5);
			vac = 10'h000;
			cyc(5);
		end
		chk(fl, 8'h01, "switching flag, no evacuation flag");
		chk(cont, !i, "continuous suction");
		sc = 0;
		cyc(4);
		chk({dg, flash, led}, 4'b1101, "switching outputs");
	endtask
	task automatic t_leak();
		rst();
		{ase, smc, sc} = 3'b111;
		vac = 10'h258;
		cyc(5);
		lsel = 3'h4;
		lv = 1;
		cyc(1);
		lv = 0;
		chk(noz, 0, "rate at limit, no resume");
		lsel = 3'h0;
		cyc(1);
		lv = 1;
		cyc(1);
		lv = 0;
		chk(noz, 1, "suction resumes");
		cyc(3);
		chk(fl, 8'h00, "first exceedance");
		lv = 1;
		cyc(1);
		lv = 0;
		cyc(3);
		chk({fl, cont, dg}, 10'h013, "second exceedance");
	endtask
	task automatic t_prs();
		rst();
		ce = 0;
		sens = 1;
		sp = 10'h320;
		cyc(3);
		chk(fl, 8'h00, "frozen while clock enable low");
		ce = 1;
		cyc(3);
		chk({evt, fl, dg, led}, 12'hC00, "pressure out of limits");
		sp = 10'h190;
		vac = 10'h122;
		sc = 1;
		cyc(10020);
		chk({fl, dg}, 9'h020, "dynamic pressure");
	endtask
	task automatic t_ana();
		rst();
		plen = 16'h0028;
		ast = 1;
		cyc(1);
		ast = 0;
		cyc(450);
		chk(code, 0, "short pulse refused");
		plen = 16'h003C;
		ast = 1;
		cyc(1);
		ast = 0;
		cyc(650);
		chk({code, o1, dg, flash, led}, 6'b111001, "analysis class 0");
		sc = 1;
		cyc(3);
		chk(code, 0, "suction ends analysis");
		repeat (2) begin
			sc = 0;
			cyc(3);
			sc = 1;
			cyc(3);
		end
		chk(cls, 16'h0001, "missed upper point raises class");
		sc = 0;
		{nc1, nc3} = 2'b11;
		cyc(3);
		ast = 1;
		cyc(1);
		ast = 0;
		cyc(650);
		chk({code, o1, dg, flash, led}, 6'b101110, "class 2, polarity ignored");
		bo = 1;
		cyc(3);
		chk(code, 0, "blow-off ends analysis");
		{bo, sc} = 2'b01;
		hys = 10'h00A;
		cyc(3);
		chk(cls, 16'h0000, "short hysteresis reads leak-tight");
	endtask
	// ********************
	// Run
	// ********************
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300000;
		failures++;
		end_sim();
	end
	initial begin
		rst();
		t_thr();
		t_evac();
		t_swf(1'b0);
		t_swf(1'b1);
		t_leak();
		t_prs();
		t_ana();
		end_sim();
	end
endmodule
